// ===== pkg/sca_cfg.svh
// Purpose: register indices, field positions and reset values
// Assumes: byte address is four times the register index
// Notes: definitions only
`ifndef SCA_CFG_SVH
`define SCA_CFG_SVH
// register indices, block 23 down to block 10
`define SCA_CR1_IDX    {8'h9d, 8'h95, 8'h89, 8'h81}
`define SCA_CR2_IDX    {8'h9e, 8'h96, 8'h8a, 8'h82}
`define SCA_CTL_IDX    {8'ha3, 8'ha2, 8'ha1, 8'ha0}
`define SCA_GLOB_IDX   8'ha4
`define SCA_STAT_IDX   8'ha5
// address slicing
`define SCA_IDX_HI     9
`define SCA_IDX_LO     2
`define SCA_ADDR_HI    11
// first control register fields
`define SCA_ACSEL_HI   7
`define SCA_ACSEL_LO   5
`define SCA_B_BRANCH_CAP_SIZE_HI    4
// second control register fields
`define SCA_COLEN_BIT  7
`define SCA_CMPEN_BIT  6
`define SCA_AZ_BIT     5
`define SCA_C_BRANCH_CAP_SIZE_HI    4
// per-block and global control fields
`define SCA_SWAP_BIT   0
`define SCA_FSW_BIT    1
`define SCA_SAMPLE_HOLD_GLOBAL_DISABLE_BIT  0
// selector codes
`define SCA_AC_SHARED  3'h4
// reset values and bus answers
`define SCA_RST8       8'h00
`define SCA_RST2       2'h0
`define SCA_RESP_OKAY  2'h0
`define SCA_RESP_SLVERR 2'h2
`define SCA_ZERO24     24'h00_0000
`define SCA_CNT_MAX    8'hff
`define SCA_CNT_ONE    8'h01
`endif

// ===== pkg/sca_pkg.sv
// Purpose: shared types of the type A mux and bus control
// Assumes: constants live in sca_cfg.svh
// Notes: types only
package sca_pkg;
	typedef logic [7:0] sca_byte_t;
	typedef logic [4:0] sca_cap_t;
	typedef logic [7:0] sca_idx_t;
	typedef enum logic [1:0] {
		SCA_SRC_NONE,
		SCA_SRC_C_FIRST,
		SCA_SRC_C_SHARED
	} sca_csrc_t;
endpackage

// ===== hdl/sca_blk.sv
// Purpose: switch and bus control of one type A block
// Assumes: phase and comparator inputs already synchronised
// Notes: every output is registered
`timescale 1ns/1ps
`include "sca_cfg.svh"
module sca_blk import sca_pkg::*; (
	// clock and reset
	input  wire logic      aclk,
	input  wire logic      aresetn,
	// register contents
	input  wire sca_byte_t cr1,
	input  wire sca_byte_t cr2,
	input  wire logic      phase_swap_select,
	input  wire logic      gated_feedback_switch_ctl,
	input  wire logic      sample_hold_global_disable,
	// phases and comparator
	input  wire logic      ph1,
	input  wire logic      ph2,
	input  wire logic      comp_in,
	// switch controls
	output logic [4:0]     a_src_r,
	output sca_csrc_t      c_src_r,
	output sca_cap_t       b_cap_r,
	output sca_cap_t       c_cap_r,
	output logic           col_oe_n_r,
	output logic           cmp_bus_r,
	output logic           cmp_lat_r,
	output logic           short_sw_r,
	output logic           in_gnd_r,
	output logic           in_amp_r,
	output logic           sum_sw_r,
	output logic           fb_sw_r
);
	logic [2:0] acs;
	logic       col_en, cmp_en, az, iph1, iph2, rise1, late2, col_drv;
	logic [4:0] a_nxt;
	sca_csrc_t  c_nxt;
	logic       iph1_d_r;
	sca_idx_t   cnt_r, len_r;

	assign acs    = cr1[`SCA_ACSEL_HI:`SCA_ACSEL_LO];
	assign col_en = cr2[`SCA_COLEN_BIT];
	assign cmp_en = cr2[`SCA_CMPEN_BIT];
	assign az     = cr2[`SCA_AZ_BIT];
	// internal phases
	assign iph1 = phase_swap_select ? ph2 : ph1;
	assign iph2 = phase_swap_select ? ph1 : ph2;
	assign rise1 = iph1 & ~iph1_d_r;
	// one-hot a source; reserved codes open all
	assign a_nxt = (acs <= `SCA_AC_SHARED) ?
		5'(5'h01 << acs) : 5'h00;
	// top bit shares the a source with c
	assign c_nxt = (acs == `SCA_AC_SHARED) ? SCA_SRC_C_SHARED :
		(~acs[2]) ? SCA_SRC_C_FIRST : SCA_SRC_NONE;
	// second half of phase two, by last measured length
	assign late2 = iph2 & (cnt_r >= (len_r >> 1));
	// column bus gating
	assign col_drv = col_en & (phase_swap_select |
		(sample_hold_global_disable ? iph2 : late2));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= `SCA_RST8;
			len_r <= `SCA_RST8;
		end else if (iph2) begin
			if (cnt_r != `SCA_CNT_MAX)
				cnt_r <= cnt_r + `SCA_CNT_ONE;
		end else if (cnt_r != `SCA_RST8) begin
			len_r <= cnt_r;
			cnt_r <= `SCA_RST8;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			iph1_d_r  <= 1'b0;
			cmp_lat_r <= 1'b0;
		end else begin
			iph1_d_r <= iph1;
			if (rise1)
				cmp_lat_r <= comp_in;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_src_r    <= 5'h00;
			c_src_r    <= SCA_SRC_NONE;
			b_cap_r    <= 5'h00;
			c_cap_r    <= 5'h00;
			col_oe_n_r <= 1'b1;
			cmp_bus_r  <= 1'b0;
			short_sw_r <= 1'b0;
			in_gnd_r   <= 1'b0;
			in_amp_r   <= 1'b0;
			sum_sw_r   <= 1'b0;
			fb_sw_r    <= 1'b0;
		end else begin
			a_src_r    <= a_nxt;
			c_src_r    <= c_nxt;
			b_cap_r    <= cr1[`SCA_B_BRANCH_CAP_SIZE_HI:0];
			c_cap_r    <= cr2[`SCA_C_BRANCH_CAP_SIZE_HI:0];
			col_oe_n_r <= ~col_drv;
			cmp_bus_r  <= cmp_en & cmp_lat_r;
			short_sw_r <= az & iph1;
			in_gnd_r   <= az & iph1;
			in_amp_r   <= ~az | iph2;
			sum_sw_r   <= az;
			fb_sw_r    <= gated_feedback_switch_ctl &
				(~az | iph2);
		end
	end
endmodule // sca_blk

// ===== hdl/sca_mux_bus_ctl.sv
// Purpose: registers and switch control of four type A blocks
// Assumes: axi4-lite slave, 25 MHz aclk, phase pins asynchronous
// Notes: block order 10, 12, 21, 23 at positions 0 to 3
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sca_cfg.svh"
module sca_mux_bus_ctl import sca_pkg::*; (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// write address
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	// write data
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// read address
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	// read data
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// phase clock and comparator pins
	input  wire logic        phase_one_clock,
	input  wire logic        phase_two_clock,
	input  wire logic [3:0]  comparator_raw,
	// mux and capacitor controls per block
	output logic [3:0][4:0]  a_branch_source_sel,
	output sca_csrc_t [3:0]  c_branch_source_sel,
	output sca_cap_t [3:0]   b_branch_cap_size,
	output sca_cap_t [3:0]   c_branch_cap_size,
	// column buses per block
	output logic [3:0]       column_analog_bus_oe_n,
	output logic [3:0]       column_comparator_bus,
	// op-amp switches per block
	output logic [3:0]       offset_short_switch,
	output logic [3:0]       input_to_ground_switch,
	output logic [3:0]       input_to_amp_switch,
	output logic [3:0]       summing_node_switch,
	output logic [3:0]       feedback_switch
);
	localparam logic [3:0][7:0] CR1_IDX = `SCA_CR1_IDX;
	localparam logic [3:0][7:0] CR2_IDX = `SCA_CR2_IDX;
	localparam logic [3:0][7:0] CTL_IDX = `SCA_CTL_IDX;

	// pin synchronisers
	logic [5:0] sync1_r;
	logic [5:0] sync2_r;
	logic       ph1_s;
	logic       ph2_s;
	logic [3:0] comp_s;

	// register file
	sca_byte_t  cr1_r [4];
	sca_byte_t  cr2_r [4];
	logic [1:0] ctl_r [4];
	logic       glob_r;
	logic [3:0] cmp_lat;

	// bus state
	logic        awready_r;
	logic        wready_r;
	logic        bvalid_r;
	logic        arready_r;
	logic        rvalid_r;
	logic        aw_have_r;
	logic        w_have_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic [1:0]  bresp_r;
	logic [1:0]  rresp_r;
	logic [31:0] rdata_r;

	// bus next values
	logic        awready_nxt;
	logic        wready_nxt;
	logic        bvalid_nxt;
	logic        arready_nxt;
	logic        rvalid_nxt;
	logic        aw_have_nxt;
	logic        w_have_nxt;
	logic [1:0]  bresp_nxt;
	logic [1:0]  rresp_nxt;
	logic [31:0] rdata_nxt;

	// decode wires
	logic        aw_take;
	logic        w_take;
	logic        ar_take;
	logic        b_done;
	logic        r_done;
	logic        aw_ok;
	logic        w_ok;
	logic        do_wr;
	logic        wr_en;
	logic [11:0] wa;
	logic [31:0] wd;
	logic [3:0]  ws;
	sca_idx_t    widx;
	sca_idx_t    ridx;
	logic        wtop_ok;
	logic        rtop_ok;
	logic [3:0]  w_cr1;
	logic [3:0]  w_cr2;
	logic [3:0]  w_ctl;
	logic [3:0]  r_cr1;
	logic [3:0]  r_cr2;
	logic [3:0]  r_ctl;
	logic        w_glob;
	logic        r_glob;
	logic        r_stat;
	logic        w_hit;
	logic        r_hit;
	sca_byte_t   racc [5];
	sca_byte_t   rval;

	assign {comp_s, ph2_s, ph1_s} = sync2_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= 6'h00;
			sync2_r <= 6'h00;
		end else begin
			sync1_r <= {comparator_raw, phase_two_clock,
				phase_one_clock};
			sync2_r <= sync1_r;
		end
	end

	// handshakes
	assign aw_take = awvalid & awready_r;
	assign w_take  = wvalid & wready_r;
	assign ar_take = arvalid & arready_r;
	assign b_done  = bvalid_r & bready;
	assign r_done  = rvalid_r & rready;
	assign aw_ok   = aw_have_r | aw_take;
	assign w_ok    = w_have_r | w_take;
	assign do_wr   = aw_ok & w_ok & ~bvalid_r;
	assign wa      = aw_have_r ? awaddr_r : awaddr;
	assign wd      = w_have_r ? wdata_r : wdata;
	assign ws      = w_have_r ? wstrb_r : wstrb;
	assign wr_en   = do_wr & ws[0];

	// address decode
	assign widx    = wa[`SCA_IDX_HI:`SCA_IDX_LO];
	assign ridx    = araddr[`SCA_IDX_HI:`SCA_IDX_LO];
	assign wtop_ok = (wa[`SCA_ADDR_HI:`SCA_IDX_HI+1] == 2'h0);
	assign rtop_ok = (araddr[`SCA_ADDR_HI:`SCA_IDX_HI+1] == 2'h0);
	assign w_glob  = wtop_ok & (widx == `SCA_GLOB_IDX);
	assign r_glob  = rtop_ok & (ridx == `SCA_GLOB_IDX);
	assign r_stat  = rtop_ok & (ridx == `SCA_STAT_IDX);
	assign w_hit   = |{w_cr1, w_cr2, w_ctl, w_glob};
	assign r_hit   = |{r_cr1, r_cr2, r_ctl, r_glob, r_stat};

	assign racc[0] = ({8{r_glob}} & {7'h00, glob_r}) |
		({8{r_stat}} & {4'h0, cmp_lat});
	assign rval = racc[4];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_blk
			assign w_cr1[g] = wtop_ok & (widx == CR1_IDX[g]);
			assign w_cr2[g] = wtop_ok & (widx == CR2_IDX[g]);
			assign w_ctl[g] = wtop_ok & (widx == CTL_IDX[g]);
			assign r_cr1[g] = rtop_ok & (ridx == CR1_IDX[g]);
			assign r_cr2[g] = rtop_ok & (ridx == CR2_IDX[g]);
			assign r_ctl[g] = rtop_ok & (ridx == CTL_IDX[g]);
			assign racc[g+1] = racc[g] |
				({8{r_cr1[g]}} & cr1_r[g]) |
				({8{r_cr2[g]}} & cr2_r[g]) |
				({8{r_ctl[g]}} & {6'h00, ctl_r[g]});

			// every bit read/write, clears at reset
			always_ff @(posedge aclk) begin
				if (!aresetn)
					cr1_r[g] <= `SCA_RST8;
				else if (wr_en & w_cr1[g])
					cr1_r[g] <= wd[7:0];
			end

			always_ff @(posedge aclk) begin
				if (!aresetn)
					cr2_r[g] <= `SCA_RST8;
				else if (wr_en & w_cr2[g])
					cr2_r[g] <= wd[7:0];
			end

			always_ff @(posedge aclk) begin
				if (!aresetn)
					ctl_r[g] <= `SCA_RST2;
				else if (wr_en & w_ctl[g])
					ctl_r[g] <= wd[1:0];
			end

			// controls follow registers and phases
			sca_blk u_blk (
				.aclk                       (aclk),
				.aresetn                    (aresetn),
				.cr1                        (cr1_r[g]),
				.cr2                        (cr2_r[g]),
				.phase_swap_select          (ctl_r[g][`SCA_SWAP_BIT]),
				.gated_feedback_switch_ctl  (ctl_r[g][`SCA_FSW_BIT]),
				.sample_hold_global_disable (glob_r),
				.ph1                        (ph1_s),
				.ph2                        (ph2_s),
				.comp_in                    (comp_s[g]),
				.a_src_r                    (a_branch_source_sel[g]),
				.c_src_r                    (c_branch_source_sel[g]),
				.b_cap_r                    (b_branch_cap_size[g]),
				.c_cap_r                    (c_branch_cap_size[g]),
				.col_oe_n_r                 (column_analog_bus_oe_n[g]),
				.cmp_bus_r                  (column_comparator_bus[g]),
				.cmp_lat_r                  (cmp_lat[g]),
				.short_sw_r                 (offset_short_switch[g]),
				.in_gnd_r                   (input_to_ground_switch[g]),
				.in_amp_r                   (input_to_amp_switch[g]),
				.sum_sw_r                   (summing_node_switch[g]),
				.fb_sw_r                    (feedback_switch[g])
			);
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn)
			glob_r <= 1'b0;
		else if (wr_en & w_glob)
			glob_r <= wd[`SCA_SAMPLE_HOLD_GLOBAL_DISABLE_BIT];
	end

	// write channel next values
	assign awready_nxt = b_done | (awready_r & ~aw_take);
	assign wready_nxt  = b_done | (wready_r & ~w_take);
	assign aw_have_nxt = ~do_wr & (aw_have_r | aw_take);
	assign w_have_nxt  = ~do_wr & (w_have_r | w_take);
	assign bvalid_nxt  = do_wr | (bvalid_r & ~b_done);
	assign bresp_nxt   = w_hit ? `SCA_RESP_OKAY : `SCA_RESP_SLVERR;

	// read channel next values
	assign arready_nxt = r_done | (arready_r & ~ar_take);
	assign rvalid_nxt  = ar_take | (rvalid_r & ~r_done);
	assign rresp_nxt   = r_hit ? `SCA_RESP_OKAY : `SCA_RESP_SLVERR;
	assign rdata_nxt   = {`SCA_ZERO24, rval};

	// ready flags, high while idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			arready_r <= 1'b1;
		end else begin
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			arready_r <= arready_nxt;
		end
	end

	// held write address and data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			awaddr_r  <= 12'h000;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
		end else begin
			aw_have_r <= aw_have_nxt;
			w_have_r  <= w_have_nxt;
			if (aw_take)
				awaddr_r <= awaddr;
			if (w_take) begin
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
		end
	end

	// write answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= `SCA_RESP_OKAY;
		end else begin
			bvalid_r <= bvalid_nxt;
			if (do_wr)
				bresp_r <= bresp_nxt;
		end
	end

	// read answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= `SCA_RESP_OKAY;
		end else begin
			rvalid_r <= rvalid_nxt;
			if (ar_take) begin
				rdata_r <= rdata_nxt;
				rresp_r <= rresp_nxt;
			end
		end
	end

	assign awready = awready_r;
	assign wready  = wready_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign arready = arready_r;
	assign rvalid  = rvalid_r;
	assign rdata   = rdata_r;
	assign rresp   = rresp_r;
endmodule // sca_mux_bus_ctl

// ===== tb/sca_mux_bus_ctl_monitor.sv
// Purpose: port checks of the type A mux and bus control
// Assumes: phase pins never high together
// Notes: bound from the bench
`timescale 1ns/1ps
module sca_mux_bus_ctl_monitor (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// bus handshakes
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [31:0] rdata,
	input wire logic        rvalid,
	input wire logic        rready,
	// phase pins and switches
	input wire logic        phase_one_clock,
	input wire logic        phase_two_clock,
	input wire logic [3:0]  offset_short_switch,
	input wire logic [3:0]  input_to_ground_switch,
	input wire logic [3:0]  input_to_amp_switch,
	input wire logic [3:0]  summing_node_switch,
	input wire logic [3:0]  feedback_switch
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_take;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_pin_high;
		$past(phase_one_clock, 3) || $past(phase_two_clock, 3);
	endsequence
	property p_wr_answer;
		s_wr_take |=> bvalid;
	endproperty
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	property p_short_gnd;
		offset_short_switch == input_to_ground_switch;
	endproperty
	property p_short_amp;
		(offset_short_switch & input_to_amp_switch) == 4'h0;
	endproperty
	property p_sum_gate;
		(offset_short_switch & ~summing_node_switch) == 4'h0;
	endproperty
	property p_amp_noaz;
		$past(aresetn) |-> (~summing_node_switch & ~input_to_amp_switch) == 4'h0;
	endproperty
	property p_fb_gate;
		(feedback_switch & ~input_to_amp_switch) == 4'h0;
	endproperty
	property p_short_phase;
		offset_short_switch[0] |-> s_pin_high;
	endproperty
	a_wr_answer: assert property (p_wr_answer)
		else $error("write answer late");
	a_b_hold: assert property (p_b_hold)
		else $error("write answer dropped");
	a_r_hold: assert property (p_r_hold)
		else $error("read answer dropped");
	a_short_gnd: assert property (p_short_gnd)
		else $error("short and ground differ");
	a_short_amp: assert property (p_short_amp)
		else $error("short with amp input");
	a_sum_gate: assert property (p_sum_gate)
		else $error("short without summing pair");
	a_amp_noaz: assert property (p_amp_noaz)
		else $error("amp input open without auto-zero");
	a_fb_gate: assert property (p_fb_gate)
		else $error("feedback outside its phase");
	a_short_phase: assert property (p_short_phase)
		else $error("short with no phase high");
endmodule // sca_mux_bus_ctl_monitor

// ===== tb/sca_mux_bus_ctl_bench.sv
// Purpose: bench of the type A mux and bus control
// Assumes: phase period 16 cycles, one high 5, two high 4
// Notes: switch tests use block 10
`timescale 1ns/1ps
`include "sca_cfg.svh"
module sca_mux_bus_ctl_bench import sca_pkg::*;;
	logic             aclk, aresetn;
	logic [11:0]      awaddr, araddr;
	logic [31:0]      wdata, rdata;
	logic [3:0]       wstrb, comparator_raw;
	logic [1:0]       bresp, rresp;
	logic             awvalid, awready, wvalid, wready, bvalid, bready;
	logic             arvalid, arready, rvalid, rready;
	logic             phase_one_clock, phase_two_clock;
	logic [3:0][4:0]  a_branch_source_sel;
	sca_csrc_t [3:0]  c_branch_source_sel;
	sca_cap_t [3:0]   b_branch_cap_size, c_branch_cap_size;
	logic [3:0]       column_analog_bus_oe_n, column_comparator_bus;
	logic [3:0]       offset_short_switch, input_to_ground_switch;
	logic [3:0]       input_to_amp_switch, summing_node_switch;
	logic [3:0]       feedback_switch;
	int               failures, checks, ph, c_sh, c_amp, c_sum, c_fb, c_oe;
	localparam logic [31:0] CR1 = `SCA_CR1_IDX;
	localparam logic [31:0] CR2 = `SCA_CR2_IDX;
	localparam logic [31:0] CTL = `SCA_CTL_IDX;
	localparam logic [31:0] GLB = {24'h00_0000, `SCA_GLOB_IDX};
	localparam logic [1:0]  OK = `SCA_RESP_OKAY;
	// cr2, ctl, glob, short, amp, sum, feedback, bus drive
	int md [6][8] = '{'{8'h00, 8'h00, 0, 0, 64, 0, 0, 0},
		'{8'h20, 8'h02, 0, 20, 16, 64, 16, 0},
		'{8'h20, 8'h03, 0, 16, 20, 64, 20, 0},
		'{8'h00, 8'h02, 0, 0, 64, 0, 64, 0},
		'{8'h80, 8'h00, 1, 0, 64, 0, 0, 16},
		'{8'h80, 8'h01, 0, 0, 64, 0, 0, 64}};
	sca_mux_bus_ctl sca_mux_bus_ctl_inst (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .phase_one_clock(phase_one_clock),
		.phase_two_clock(phase_two_clock), .comparator_raw(comparator_raw),
		.a_branch_source_sel(a_branch_source_sel),
		.c_branch_source_sel(c_branch_source_sel),
		.b_branch_cap_size(b_branch_cap_size),
		.c_branch_cap_size(c_branch_cap_size),
		.column_analog_bus_oe_n(column_analog_bus_oe_n),
		.column_comparator_bus(column_comparator_bus),
		.offset_short_switch(offset_short_switch),
		.input_to_ground_switch(input_to_ground_switch),
		.input_to_amp_switch(input_to_amp_switch),
		.summing_node_switch(summing_node_switch),
		.feedback_switch(feedback_switch));
	always #20 aclk = ~aclk;
	always @(posedge aclk) begin
		ph <= (ph + 1) % 16;
		phase_one_clock <= ph < 5;
		phase_two_clock <= ph >= 8 && ph < 12;
	end
	function automatic logic [11:0] adr(input logic [31:0] t, input int i);
		return {2'b00, t[i*8+:8], 2'b00};
	endfunction
	task automatic chk(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] s, input logic [1:0] er);
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		wstrb <= s;
		fork
			begin
				awvalid <= 1'b1;
				do @(posedge aclk); while (!awready);
				awvalid <= 1'b0;
			end
			begin
				wvalid <= 1'b1;
				do @(posedge aclk); while (!wready);
				wvalid <= 1'b0;
			end
		join
		@(posedge aclk);
		bready <= 1'b1;
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
		chk("bresp", {30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e,
		input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		@(posedge aclk);
		rready <= 1'b1;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
		chk("rdata", rdata, {24'h00_0000, e});
		chk("rresp", {30'h0, rresp}, {30'h0, er});
	endtask
	task automatic measure();
		{c_sh, c_amp, c_sum, c_fb, c_oe} = '0;
		repeat (20) @(posedge aclk);
		repeat (64) begin
			@(posedge aclk);
			c_sh += offset_short_switch[0];
			c_amp += input_to_amp_switch[0];
			c_sum += summing_node_switch[0];
			c_fb += feedback_switch[0];
			c_oe += !column_analog_bus_oe_n[0];
		end
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#400_000;
		failures++;
		conclude();
	end
	initial begin
		{aclk, aresetn, awaddr, awvalid, wdata, wstrb, wvalid} = '0;
		{bready, araddr, arvalid, rready, comparator_raw} = '0;
		{phase_one_clock, phase_two_clock, ph, failures, checks} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("oe_rst", {28'h0, column_analog_bus_oe_n}, 32'hf);
		for (int i = 0; i < 4; i++) begin
			rd(adr(CR1, i), 8'h00, OK);
			rd(adr(CR2, i), 8'h00, OK);
			wr(adr(CR1, i), {i[2:0], 5'(31 - i)}, 4'h1, OK);
			wr(adr(CR2, i), {3'h0, 5'(i * 7)}, 4'h1, OK);
			rd(adr(CR1, i), {i[2:0], 5'(31 - i)}, OK);
			chk("b_branch_cap_size", b_branch_cap_size[i], 32'(31 - i));
			chk("c_branch_cap_size", c_branch_cap_size[i], 32'(i * 7));
		end
		wr(adr(CR1, 0), 8'hff, 4'h0, OK);
		rd(adr(CR1, 0), 8'h1f, OK);
		wr(12'h400, 8'hff, 4'h1, `SCA_RESP_SLVERR);
		rd(12'h400, 8'h00, `SCA_RESP_SLVERR);
		for (int c = 0; c < 8; c++) begin
			wr(adr(CR1, 0), {c[2:0], 5'h00}, 4'h1, OK);
			repeat (4) @(posedge aclk);
			chk("asel", a_branch_source_sel[0], c < 5 ? 32'h1 << c : 32'h0);
			chk("csel", c_branch_source_sel[0], c == 4 ? SCA_SRC_C_SHARED :
				c > 4 ? SCA_SRC_NONE : SCA_SRC_C_FIRST);
		end
		for (int m = 0; m < 6; m++) begin
			wr(adr(CR2, 0), md[m][0][7:0], 4'h1, OK);
			wr(adr(CTL, 0), md[m][1][7:0], 4'h1, OK);
			wr(adr(GLB, 0), md[m][2][7:0], 4'h1, OK);
			measure();
			chk("short", c_sh, md[m][3]);
			chk("amp", c_amp, md[m][4]);
			chk("sum", c_sum, md[m][5]);
			chk("fb", c_fb, md[m][6]);
			chk("colbus", c_oe, md[m][7]);
		end
		wr(adr(CTL, 0), 8'h00, 4'h1, OK);
		measure();
		chk("gated", c_oe, 8);
		wr(adr(CR2, 0), 8'h40, 4'h1, OK);
		comparator_raw <= 4'hf;
		measure();
		chk("column_comparator_bus", {28'h0, column_comparator_bus}, 32'h1);
		comparator_raw <= 4'h0;
		measure();
		chk("column_comparator_bus", {28'h0, column_comparator_bus}, 32'h0);
		conclude();
	end
endmodule // sca_mux_bus_ctl_bench
bind sca_mux_bus_ctl sca_mux_bus_ctl_monitor sca_mux_bus_ctl_monitor_inst (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
	.phase_one_clock(phase_one_clock), .phase_two_clock(phase_two_clock),
	.offset_short_switch(offset_short_switch),
	.input_to_ground_switch(input_to_ground_switch),
	.input_to_amp_switch(input_to_amp_switch),
	.summing_node_switch(summing_node_switch),
	.feedback_switch(feedback_switch));
